// ==== eag_pkg.sv ====
/*
 * eag_pkg: shared constants and types of the effective address generator.
 * assumes: nothing beyond a SystemVerilog compiler; no timescale here.
 */
package eag_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int ADDR_W = 32;
    localparam int DISP4_W = 4;
    localparam int DISP8_W = 8;
    localparam int DISP12_W = 12;
    localparam int IMM_W = 8;
    localparam int MIN_ADDR_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // operand size codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    localparam logic [1:0] SIZE_RSVD = 2'h3;

    // shift amounts for scaling: x1, x2, x4
    localparam logic [1:0] SHIFT_BYTE = 2'h0;
    localparam logic [1:0] SHIFT_WORD = 2'h1;
    localparam logic [1:0] SHIFT_LONG = 2'h2;
    localparam logic [1:0] SHIFT_BRANCH = 2'h1;
    localparam logic [1:0] SHIFT_TRAP = 2'h2;

    // step values for post-increment and pre-decrement
    localparam logic [2:0] STEP_BYTE = 3'h1;
    localparam logic [2:0] STEP_WORD = 3'h2;
    localparam logic [2:0] STEP_LONG = 3'h4;

    // longword pc-relative base mask
    localparam logic [31:0] PC_LONG_MASK = 32'hffff_fffc;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // addressing and immediate modes
    typedef enum logic [3:0] {
        EAG_REG_DIRECT,
        EAG_REG_IND,
        EAG_POST_INC,
        EAG_PRE_DEC,
        EAG_REG_DISP,
        EAG_IDX_REG,
        EAG_GBR_DISP,
        EAG_IDX_GBR,
        EAG_PC_DISP,
        EAG_BR_DISP8,
        EAG_BR_DISP12,
        EAG_BR_REG,
        EAG_IMM_ZERO,
        EAG_IMM_SIGN,
        EAG_IMM_TRAP
    } eag_mode_t;

endpackage

// ==== eag_scale.sv ====
/*
 * eag_scale: zero-extends a displacement field and scales it by 1, 2 or 4.
 * assumes: purely combinational; the caller decides which sizes are legal.
 */
`timescale 1ns/100ps

module eag_scale #(
    parameter int DISP_W = 4,
    parameter int OUT_W = 32
) (
    // displacement field
    input wire logic [DISP_W-1:0] disp_i,
    // operand size code
    input wire logic [1:0] size_i,
    // zero-extended scaled value
    output logic [OUT_W-1:0] scaled_o
);

    if (DISP_W < 1 || OUT_W < DISP_W + 2) begin : g_bad_width
        $error("eag_scale: output too narrow for scaled displacement");
    end

    logic [OUT_W-1:0] zext;

    assign zext = {{(OUT_W-DISP_W){1'b0}}, disp_i};

    always_comb begin
        case (size_i)
            eag_pkg::SIZE_BYTE: scaled_o = zext << eag_pkg::SHIFT_BYTE;
            eag_pkg::SIZE_WORD: scaled_o = zext << eag_pkg::SHIFT_WORD;
            eag_pkg::SIZE_LONG: scaled_o = zext << eag_pkg::SHIFT_LONG;
            default: scaled_o = '0;
        endcase
    end

endmodule

// ==== eag_core.sv ====
/*
 * eag_core: effective address generator of a 32-bit core with 16-bit
 * instructions; one request per cycle, results registered one cycle later.
 * assumes: decoder presents mode, size, register values and fields
 * synchronous to clk_i; the register file applies the write-back.
 */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - register direct: the register itself is the operand, no address
// - register indirect: register contents are the address, register untouched
// - post-increment: address is register; register then grows by 1/2/4
// - pre-decrement: register shrinks by 1/2/4 first, written back, used as address
// - register plus 4-bit displacement, zero-extended, scaled by size
// - indexed register: general register plus index register zero
// - base register plus 8-bit displacement, zero-extended, scaled by size
// - indexed base: base register plus index register zero
// - pc-relative data: 8-bit zero-extended displacement times 2 or 4 plus pc
// - longword pc-relative data clears the two low pc bits first
// - 8-bit branch: sign-extend, times 2, add to pc
// - 12-bit branch: sign-extend, times 2, add to pc
// - register branch: pc plus general register
// - test/and/or/xor immediate is zero-extended to 32 bits
// - move/add/compare-equal immediate is sign-extended to 32 bits
// - trap immediate is zero-extended and multiplied by 4
module eag_core #(
    parameter int ADDR_W = eag_pkg::ADDR_W
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // request from decoder
    input wire logic req_valid_i,
    input wire eag_pkg::eag_mode_t mode_i,
    input wire logic [1:0] size_i,
    input wire logic [eag_pkg::DISP12_W-1:0] disp_i,
    input wire logic [eag_pkg::IMM_W-1:0] imm_i,
    // register values
    input wire logic [ADDR_W-1:0] general_reg_n_i,
    input wire logic [ADDR_W-1:0] index_reg_zero_i,
    input wire logic [ADDR_W-1:0] global_base_reg_i,
    input wire logic [ADDR_W-1:0] pc_i,
    // memory address result
    output logic ea_valid_o,
    output logic [ADDR_W-1:0] ea_o,
    // register direct operand
    output logic opnd_valid_o,
    output logic [ADDR_W-1:0] opnd_o,
    // register write-back
    output logic wb_en_o,
    output logic wb_pre_o,
    output logic [ADDR_W-1:0] wb_data_o,
    // branch target
    output logic tgt_valid_o,
    output logic [ADDR_W-1:0] tgt_o,
    // extended immediate or trap vector offset
    output logic imm_valid_o,
    output logic [ADDR_W-1:0] imm_o,
    // illegal size for the requested mode
    output logic size_err_o
);

    // masks and checks are written for the full 32-bit word
    if (ADDR_W < eag_pkg::MIN_ADDR_W || ADDR_W > eag_pkg::ADDR_W) begin : g_bad_width
        $error("eag_core: ADDR_W outside supported range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // operand decode

    logic take;
    logic [2:0] step;
    logic [ADDR_W-1:0] step_w;
    logic [ADDR_W-1:0] disp4_scaled;
    logic [ADDR_W-1:0] disp8_scaled;
    logic [ADDR_W-1:0] pc_base;
    logic [ADDR_W-1:0] br8_off;
    logic [ADDR_W-1:0] br12_off;
    logic [ADDR_W-1:0] pc_mask;
    logic size_ok;
    logic pc_size_ok;

    assign take = req_valid_i && clk_en_i;

    always_comb begin
        case (size_i)
            eag_pkg::SIZE_BYTE: step = eag_pkg::STEP_BYTE;
            eag_pkg::SIZE_WORD: step = eag_pkg::STEP_WORD;
            eag_pkg::SIZE_LONG: step = eag_pkg::STEP_LONG;
            default: step = 3'h0;
        endcase
    end

    assign step_w = {{(ADDR_W-3){1'b0}}, step};
    assign size_ok = (size_i != eag_pkg::SIZE_RSVD);
    // pc-relative data has no byte form
    assign pc_size_ok = (size_i == eag_pkg::SIZE_WORD) || (size_i == eag_pkg::SIZE_LONG);

    eag_scale #(
        .DISP_W(eag_pkg::DISP4_W),
        .OUT_W(ADDR_W)
    ) u_scale_d4 (
        .disp_i(disp_i[eag_pkg::DISP4_W-1:0]),
        .size_i(size_i),
        .scaled_o(disp4_scaled)
    );

    eag_scale #(
        .DISP_W(eag_pkg::DISP8_W),
        .OUT_W(ADDR_W)
    ) u_scale_d8 (
        .disp_i(disp_i[eag_pkg::DISP8_W-1:0]),
        .size_i(size_i),
        .scaled_o(disp8_scaled)
    );

    assign pc_mask = eag_pkg::PC_LONG_MASK[ADDR_W-1:0];
    assign pc_base = (size_i == eag_pkg::SIZE_LONG) ? (pc_i & pc_mask) : pc_i;

    // sign-extended branch offsets, times 2
    assign br8_off = {{(ADDR_W-eag_pkg::DISP8_W){disp_i[eag_pkg::DISP8_W-1]}},
                      disp_i[eag_pkg::DISP8_W-1:0]} << eag_pkg::SHIFT_BRANCH;
    assign br12_off = {{(ADDR_W-eag_pkg::DISP12_W){disp_i[eag_pkg::DISP12_W-1]}},
                       disp_i} << eag_pkg::SHIFT_BRANCH;

    ////////////////////////////////////////////////////////////////////////////
    // next values

    logic ea_valid_d;
    logic [ADDR_W-1:0] ea_d;
    logic opnd_valid_d;
    logic wb_en_d;
    logic wb_pre_d;
    logic [ADDR_W-1:0] wb_data_d;
    logic tgt_valid_d;
    logic [ADDR_W-1:0] tgt_d;
    logic imm_valid_d;
    logic [ADDR_W-1:0] imm_d;
    logic size_err_d;

    always_comb begin
        ea_valid_d = 1'b0;
        ea_d = general_reg_n_i;
        opnd_valid_d = 1'b0;
        wb_en_d = 1'b0;
        wb_pre_d = 1'b0;
        wb_data_d = general_reg_n_i;
        tgt_valid_d = 1'b0;
        tgt_d = pc_i;
        imm_valid_d = 1'b0;
        imm_d = '0;
        size_err_d = 1'b0;
        case (mode_i)
            eag_pkg::EAG_REG_DIRECT: opnd_valid_d = 1'b1;
            eag_pkg::EAG_REG_IND: begin
                ea_valid_d = size_ok;
                size_err_d = !size_ok;
            end
            eag_pkg::EAG_POST_INC: begin
                ea_valid_d = size_ok;
                wb_en_d = size_ok;
                wb_data_d = general_reg_n_i + step_w;
                size_err_d = !size_ok;
            end
            eag_pkg::EAG_PRE_DEC: begin
                ea_valid_d = size_ok;
                ea_d = general_reg_n_i - step_w;
                wb_en_d = size_ok;
                wb_pre_d = size_ok;
                wb_data_d = general_reg_n_i - step_w;
                size_err_d = !size_ok;
            end
            eag_pkg::EAG_REG_DISP: begin
                ea_valid_d = size_ok;
                ea_d = general_reg_n_i + disp4_scaled;
                size_err_d = !size_ok;
            end
            eag_pkg::EAG_IDX_REG: begin
                ea_valid_d = size_ok;
                ea_d = general_reg_n_i + index_reg_zero_i;
                size_err_d = !size_ok;
            end
            eag_pkg::EAG_GBR_DISP: begin
                ea_valid_d = size_ok;
                ea_d = global_base_reg_i + disp8_scaled;
                size_err_d = !size_ok;
            end
            eag_pkg::EAG_IDX_GBR: begin
                ea_valid_d = size_ok;
                ea_d = global_base_reg_i + index_reg_zero_i;
                size_err_d = !size_ok;
            end
            eag_pkg::EAG_PC_DISP: begin
                ea_valid_d = pc_size_ok;
                ea_d = pc_base + disp8_scaled;
                size_err_d = !pc_size_ok;
            end
            eag_pkg::EAG_BR_DISP8: begin
                tgt_valid_d = 1'b1;
                tgt_d = pc_i + br8_off;
            end
            eag_pkg::EAG_BR_DISP12: begin
                tgt_valid_d = 1'b1;
                tgt_d = pc_i + br12_off;
            end
            eag_pkg::EAG_BR_REG: begin
                tgt_valid_d = 1'b1;
                tgt_d = pc_i + general_reg_n_i;
            end
            eag_pkg::EAG_IMM_ZERO: begin
                imm_valid_d = 1'b1;
                imm_d = {{(ADDR_W-eag_pkg::IMM_W){1'b0}}, imm_i};
            end
            eag_pkg::EAG_IMM_SIGN: begin
                imm_valid_d = 1'b1;
                imm_d = {{(ADDR_W-eag_pkg::IMM_W){imm_i[eag_pkg::IMM_W-1]}}, imm_i};
            end
            eag_pkg::EAG_IMM_TRAP: begin
                imm_valid_d = 1'b1;
                imm_d = {{(ADDR_W-eag_pkg::IMM_W){1'b0}}, imm_i} << eag_pkg::SHIFT_TRAP;
            end
            default: size_err_d = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // strobes: set from each taken request, held unchanged while clk_en_i is low

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ea_valid_o <= 1'b0;
            opnd_valid_o <= 1'b0;
            wb_en_o <= 1'b0;
            tgt_valid_o <= 1'b0;
            imm_valid_o <= 1'b0;
            size_err_o <= 1'b0;
        end else if (clk_en_i) begin
            ea_valid_o <= take && ea_valid_d;
            opnd_valid_o <= take && opnd_valid_d;
            wb_en_o <= take && wb_en_d;
            tgt_valid_o <= take && tgt_valid_d;
            imm_valid_o <= take && imm_valid_d;
            size_err_o <= take && size_err_d;
        end
    end

    // data words hold between requests
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ea_o <= eag_pkg::RST_WORD[ADDR_W-1:0];
            opnd_o <= eag_pkg::RST_WORD[ADDR_W-1:0];
        end else if (take) begin
            ea_o <= ea_d;
            opnd_o <= general_reg_n_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wb_pre_o <= 1'b0;
            wb_data_o <= eag_pkg::RST_WORD[ADDR_W-1:0];
        end else if (take) begin
            wb_pre_o <= wb_pre_d;
            wb_data_o <= wb_data_d;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tgt_o <= eag_pkg::RST_WORD[ADDR_W-1:0];
            imm_o <= eag_pkg::RST_WORD[ADDR_W-1:0];
        end else if (take) begin
            tgt_o <= tgt_d;
            imm_o <= imm_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence req_s(eag_pkg::eag_mode_t m);
        take && mode_i == m;
    endsequence

    sequence ok_req_s(eag_pkg::eag_mode_t m);
        take && mode_i == m && size_i != eag_pkg::SIZE_RSVD;
    endsequence

    direct_opnd_a: assert property (req_s(eag_pkg::EAG_REG_DIRECT) |=>
        opnd_valid_o && !ea_valid_o && !wb_en_o && opnd_o == $past(general_reg_n_i))
        else $error("register direct operand wrong");

    indirect_ea_a: assert property (ok_req_s(eag_pkg::EAG_REG_IND) |=>
        ea_valid_o && !wb_en_o && ea_o == $past(general_reg_n_i))
        else $error("register indirect address wrong");

    post_inc_a: assert property (ok_req_s(eag_pkg::EAG_POST_INC) |=>
        ea_o == $past(general_reg_n_i) && wb_en_o && !wb_pre_o
        && wb_data_o - ea_o == ($past(size_i) == eag_pkg::SIZE_BYTE ? 32'h1 :
                                $past(size_i) == eag_pkg::SIZE_WORD ? 32'h2 : 32'h4))
        else $error("post-increment write-back wrong");

    pre_dec_a: assert property (ok_req_s(eag_pkg::EAG_PRE_DEC) |=>
        wb_en_o && wb_pre_o && wb_data_o == ea_o
        && $past(general_reg_n_i) - ea_o == ($past(size_i) == eag_pkg::SIZE_BYTE ? 32'h1 :
                                              $past(size_i) == eag_pkg::SIZE_WORD ? 32'h2 : 32'h4))
        else $error("pre-decrement address wrong");

    reg_disp_a: assert property (ok_req_s(eag_pkg::EAG_REG_DISP) |=>
        ea_o == $past(general_reg_n_i) + ({28'h0, $past(disp_i[3:0])} << $past(size_i)))
        else $error("register displacement address wrong");

    idx_sum_a: assert property (ok_req_s(eag_pkg::EAG_IDX_REG) |=>
        ea_o == $past(general_reg_n_i) + $past(index_reg_zero_i))
        else $error("indexed register address wrong");

    gbr_disp_a: assert property (ok_req_s(eag_pkg::EAG_GBR_DISP) |=>
        ea_o == $past(global_base_reg_i) + ({24'h0, $past(disp_i[7:0])} << $past(size_i)))
        else $error("base displacement address wrong");

    gbr_idx_a: assert property (ok_req_s(eag_pkg::EAG_IDX_GBR) |=>
        ea_o == $past(global_base_reg_i) + $past(index_reg_zero_i))
        else $error("indexed base address wrong");

    pc_word_a: assert property (take && mode_i == eag_pkg::EAG_PC_DISP && size_i == eag_pkg::SIZE_WORD
        |=> ea_valid_o && ea_o == $past(pc_i) + {23'h0, $past(disp_i[7:0]), 1'b0})
        else $error("pc-relative word address wrong");

    pc_long_a: assert property (take && mode_i == eag_pkg::EAG_PC_DISP && size_i == eag_pkg::SIZE_LONG
        |=> ea_valid_o && ea_o[1:0] == 2'h0
        && ea_o == {$past(pc_i[31:2]), 2'h0} + {22'h0, $past(disp_i[7:0]), 2'h0})
        else $error("pc-relative longword address wrong");

    br8_tgt_a: assert property (req_s(eag_pkg::EAG_BR_DISP8) |=>
        tgt_valid_o && tgt_o - $past(pc_i) == {{23{$past(disp_i[7])}}, $past(disp_i[7:0]), 1'b0})
        else $error("8-bit branch target wrong");

    br12_tgt_a: assert property (req_s(eag_pkg::EAG_BR_DISP12) |=>
        tgt_valid_o && tgt_o - $past(pc_i) == {{19{$past(disp_i[11])}}, $past(disp_i), 1'b0})
        else $error("12-bit branch target wrong");

    br_reg_a: assert property (req_s(eag_pkg::EAG_BR_REG) |=>
        tgt_valid_o && tgt_o == $past(pc_i) + $past(general_reg_n_i))
        else $error("register branch target wrong");

    imm_zero_a: assert property (req_s(eag_pkg::EAG_IMM_ZERO) |=>
        imm_valid_o && imm_o[31:8] == 24'h0 && imm_o[7:0] == $past(imm_i))
        else $error("zero-extended immediate wrong");

    imm_sign_a: assert property (req_s(eag_pkg::EAG_IMM_SIGN) |=>
        imm_valid_o && imm_o == {{24{$past(imm_i[7])}}, $past(imm_i)})
        else $error("sign-extended immediate wrong");

    trap_off_a: assert property (req_s(eag_pkg::EAG_IMM_TRAP) |=>
        imm_valid_o && imm_o == {22'h0, $past(imm_i), 2'h0})
        else $error("trap vector offset wrong");

    wrap_sum_a: assert property (ok_req_s(eag_pkg::EAG_POST_INC)
        and general_reg_n_i == 32'hffff_ffff |=> wb_data_o < 32'h4)
        else $error("post-increment does not wrap");

    pulse_once_a: assert property (ea_valid_o
        |-> $past(take) || ($past(ea_valid_o) && !$past(clk_en_i)))
        else $error("address strobe without request");

endmodule

// ==== eag_regfile_model.sv ====
/*
 * eag_regfile_model: one general register of the register file facing the
 * effective address generator; preloaded by the bench, updated by write-back.
 * assumes: write-back strobe is a one-cycle pulse on clk_i.
 */
`timescale 1ns/100ps

module eag_regfile_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // preload from bench
    input wire logic ld_i,
    input wire logic [31:0] ld_data_i,
    // write-back from generator
    input wire logic wb_en_i,
    input wire logic [31:0] wb_data_i,
    // register value
    output logic [31:0] reg_o
);
    logic [31:0] reg_q;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_q <= 32'h0000_0000;
        end else if (ld_i) begin
            reg_q <= ld_data_i;
        end else if (wb_en_i) begin
            reg_q <= wb_data_i;
        end
    end

    assign reg_o = reg_q;
endmodule

// ==== tb.sv ====
/*
 * tb: self-checking bench of eag_core with a register model on the
 * general register and write-back path.
 * assumes: eag_pkg and eag_core compiled first; one-cycle answer latency.
 */
`timescale 1ns/100ps

module tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic req_valid_i = 1'b0;
    eag_pkg::eag_mode_t mode_i = eag_pkg::EAG_REG_DIRECT;
    logic [1:0] size_i = 2'h0;
    logic [11:0] disp_i = 12'h000;
    logic [7:0] imm_i = 8'h00;
    logic [31:0] gr, r0 = 32'h0, global_base_reg = 32'h0, pc = 32'h0;
    logic ld = 1'b0;
    logic [31:0] ld_data = 32'h0;
    logic ea_valid_o, opnd_valid_o, wb_en_o, wb_pre_o, tgt_valid_o, imm_valid_o, size_err_o;
    logic [31:0] ea_o, opnd_o, wb_data_o, tgt_o, imm_o;
    int n_fail = 0;
    int n_tests = 0;

    always #5 clk_i = ~clk_i;

    eag_core dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i),
        .mode_i(mode_i), .size_i(size_i), .disp_i(disp_i), .imm_i(imm_i), .general_reg_n_i(gr),
        .index_reg_zero_i(r0), .global_base_reg_i(global_base_reg), .pc_i(pc), .ea_valid_o(ea_valid_o), .ea_o(ea_o),
        .opnd_valid_o(opnd_valid_o), .opnd_o(opnd_o), .wb_en_o(wb_en_o), .wb_pre_o(wb_pre_o),
        .wb_data_o(wb_data_o), .tgt_valid_o(tgt_valid_o), .tgt_o(tgt_o), .imm_valid_o(imm_valid_o),
        .imm_o(imm_o), .size_err_o(size_err_o));

    eag_regfile_model regs_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ld_i(ld), .ld_data_i(ld_data),
        .wb_en_i(wb_en_o), .wb_data_i(wb_data_o), .reg_o(gr));

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("n_tests=%0d n_fail=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic load_reg(input logic [31:0] v);
        ld = 1'b1;
        ld_data = v;
        @(posedge clk_i);
        #1 ld = 1'b0;
    endtask

    // idle edge first: the strobe never falls and rises in one time step
    task automatic do_req(input eag_pkg::eag_mode_t m, input logic [1:0] s, input logic [11:0] d,
                          input logic [7:0] im);
        @(posedge clk_i);
        #1 mode_i = m;
        size_i = s;
        disp_i = d;
        imm_i = im;
        req_valid_i = 1'b1;
        @(posedge clk_i);
        #1 req_valid_i = 1'b0;
    endtask

    // shared by post-increment and pre-decrement
    task automatic step_case(input eag_pkg::eag_mode_t m, input logic [1:0] s, input logic [31:0] start,
                             input logic [31:0] step);
        logic pre;
        logic [31:0] nxt;
        pre = (m == eag_pkg::EAG_PRE_DEC);
        nxt = pre ? start - step : start + step;
        load_reg(start);
        do_req(m, s, 12'h000, 8'h00);
        chk_bit(ea_valid_o, 1'b1);
        chk_val(ea_o, pre ? nxt : start);
        chk_bit(wb_en_o, 1'b1);
        chk_bit(wb_pre_o, pre);
        chk_val(wb_data_o, nxt);
        @(posedge clk_i);
        #1 chk_val(gr, nxt);
        chk_bit(ea_valid_o, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_direct();
        load_reg(32'h1234_5678);
        do_req(eag_pkg::EAG_REG_DIRECT, eag_pkg::SIZE_LONG, 12'h000, 8'h00);
        chk_bit(opnd_valid_o, 1'b1);
        chk_val(opnd_o, 32'h1234_5678);
        chk_bit(ea_valid_o, 1'b0);
    endtask

    task automatic t_indirect();
        load_reg(32'h8000_0003);
        do_req(eag_pkg::EAG_REG_IND, eag_pkg::SIZE_BYTE, 12'h000, 8'h00);
        chk_bit(ea_valid_o, 1'b1);
        chk_val(ea_o, 32'h8000_0003);
        chk_bit(wb_en_o, 1'b0);
    endtask

    task automatic t_post_inc();
        step_case(eag_pkg::EAG_POST_INC, eag_pkg::SIZE_BYTE, 32'h0000_0100, 32'h1);
        step_case(eag_pkg::EAG_POST_INC, eag_pkg::SIZE_WORD, 32'h0000_0100, 32'h2);
        step_case(eag_pkg::EAG_POST_INC, eag_pkg::SIZE_LONG, 32'hffff_ffff, 32'h4);
    endtask

    task automatic t_pre_dec();
        step_case(eag_pkg::EAG_PRE_DEC, eag_pkg::SIZE_BYTE, 32'h0000_0100, 32'h1);
        step_case(eag_pkg::EAG_PRE_DEC, eag_pkg::SIZE_WORD, 32'h0000_0001, 32'h2);
        step_case(eag_pkg::EAG_PRE_DEC, eag_pkg::SIZE_LONG, 32'h0000_0100, 32'h4);
    endtask

    task automatic t_disp();
        load_reg(32'h0000_1000);
        global_base_reg = 32'h0000_2000;
        for (int i = 0; i < 3; i++) begin
            do_req(eag_pkg::EAG_REG_DISP, 2'(i), 12'hfff, 8'h00);
            chk_val(ea_o, 32'h0000_1000 + (32'h0f << i));
            do_req(eag_pkg::EAG_GBR_DISP, 2'(i), 12'hfff, 8'h00);
            chk_val(ea_o, 32'h0000_2000 + (32'hff << i));
        end
    endtask

    task automatic t_index();
        load_reg(32'h0000_1000);
        r0 = 32'hffff_fff0;
        global_base_reg = 32'h0000_0040;
        do_req(eag_pkg::EAG_IDX_REG, eag_pkg::SIZE_LONG, 12'h000, 8'h00);
        chk_val(ea_o, 32'h0000_0ff0);
        do_req(eag_pkg::EAG_IDX_GBR, eag_pkg::SIZE_LONG, 12'h000, 8'h00);
        chk_val(ea_o, 32'h0000_0030);
    endtask

    task automatic t_pc_disp();
        pc = 32'h0000_1003;
        do_req(eag_pkg::EAG_PC_DISP, eag_pkg::SIZE_WORD, 12'h0ff, 8'h00);
        chk_val(ea_o, 32'h0000_1201);
        do_req(eag_pkg::EAG_PC_DISP, eag_pkg::SIZE_LONG, 12'h0ff, 8'h00);
        chk_val(ea_o, 32'h0000_13fc);
        do_req(eag_pkg::EAG_PC_DISP, eag_pkg::SIZE_BYTE, 12'h0ff, 8'h00);
        chk_bit(size_err_o, 1'b1);
        chk_bit(ea_valid_o, 1'b0);
    endtask

    task automatic t_branch();
        pc = 32'h0000_1000;
        load_reg(32'hffff_f000);
        do_req(eag_pkg::EAG_BR_DISP8, eag_pkg::SIZE_BYTE, 12'hf80, 8'h00);
        chk_val(tgt_o, 32'h0000_0f00);
        do_req(eag_pkg::EAG_BR_DISP8, eag_pkg::SIZE_BYTE, 12'h07f, 8'h00);
        chk_val(tgt_o, 32'h0000_10fe);
        do_req(eag_pkg::EAG_BR_DISP12, eag_pkg::SIZE_BYTE, 12'h800, 8'h00);
        chk_val(tgt_o, 32'h0000_0000);
        do_req(eag_pkg::EAG_BR_DISP12, eag_pkg::SIZE_BYTE, 12'h7ff, 8'h00);
        chk_val(tgt_o, 32'h0000_1ffe);
        do_req(eag_pkg::EAG_BR_REG, eag_pkg::SIZE_BYTE, 12'h000, 8'h00);
        chk_bit(tgt_valid_o, 1'b1);
        chk_val(tgt_o, 32'h0000_0000);
    endtask

    task automatic t_imm();
        do_req(eag_pkg::EAG_IMM_ZERO, eag_pkg::SIZE_BYTE, 12'h000, 8'h80);
        chk_val(imm_o, 32'h0000_0080);
        do_req(eag_pkg::EAG_IMM_SIGN, eag_pkg::SIZE_BYTE, 12'h000, 8'h80);
        chk_val(imm_o, 32'hffff_ff80);
        do_req(eag_pkg::EAG_IMM_SIGN, eag_pkg::SIZE_BYTE, 12'h000, 8'h7f);
        chk_val(imm_o, 32'h0000_007f);
        do_req(eag_pkg::EAG_IMM_TRAP, eag_pkg::SIZE_BYTE, 12'h000, 8'hff);
        chk_bit(imm_valid_o, 1'b1);
        chk_val(imm_o, 32'h0000_03fc);
    endtask

    // reserved size, then a request while the clock enable is low
    task automatic t_misc();
        load_reg(32'h0000_0200);
        do_req(eag_pkg::EAG_REG_IND, eag_pkg::SIZE_RSVD, 12'h000, 8'h00);
        chk_bit(size_err_o, 1'b1);
        chk_bit(ea_valid_o, 1'b0);
        clk_en_i = 1'b0;
        do_req(eag_pkg::EAG_POST_INC, eag_pkg::SIZE_LONG, 12'h000, 8'h00);
        chk_bit(size_err_o, 1'b1);
        chk_bit(wb_en_o, 1'b0);
        clk_en_i = 1'b1;
        @(posedge clk_i);
        #1 chk_bit(size_err_o, 1'b0);
        chk_bit(wb_en_o, 1'b0);
        chk_val(gr, 32'h0000_0200);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        #1 chk_bit(ea_valid_o, 1'b0);
        sys_rst_i = 1'b0;
        t_direct();
        t_indirect();
        t_post_inc();
        t_pre_dec();
        t_disp();
        t_index();
        t_pc_disp();
        t_branch();
        t_imm();
        t_misc();
        give_verdict();
    end

    // watchdog, far beyond the under a hundred cycles the tests take
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
endmodule
